// ==== verilog/cfis_top.v ====
// Flag update and interrupt sequencer with AHB-Lite register access
// Summary of operation
// - Add and add-with-carry set half-carry from bit 3 carry, else clear.
// - Mask flag set blocks every maskable interrupt; clear lets them in.
// - Mask flag is set after stacking, before vector fetch.
// - Requests under mask stay pending and are taken once mask clears; the core has no latch and sees a request only while its source holds it.
// - Return from interrupt restores all stacked registers including mask.
// - Reset sets mask; clear-mask, wait, or a return that unstacks a clear mask clears it.
// - Negative flag follows bit 7 of each arithmetic, logic, load or shift result.
// - Zero flag set when result of operation or load is zero.
// - Carry from bit 7 out; also updated by bit test and shifts.
// - Increment and decrement leave the carry flag alone.
// - Interrupt waits for current instruction end; reset acts at once.
// - Interrupt taken only with mask clear and local enable set.
// - Finish, stack, set mask, then pick highest vector location pending.
// - Vectors sit in top twelve bytes, two bytes per source.
// - Any reset loads program counter from reset vector and sets mask.
// - Return unstacks and resumes at the instruction next when taken.
// - Software trap ignores mask, own vector; pending hardware goes first.
// - External request pin is synchronised before evaluation.
// - Entry uses five stack bytes in a 64-byte wrapping stack.
// - Flag register reads with its three upper bits as ones.
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "cfis_defines.vh"
module cfis_top (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ext_irq_n,
    input wire i_ser_req,
    input wire i_tmr_req,
    input wire i_mft_req,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    output reg [15:0] o_stack_addr,
    output reg [7:0] o_stack_data,
    output reg o_stack_we,
    output reg [15:0] o_vector_addr,
    output reg o_vector_fetch
);
    localparam ST_RUN = 6'b000001;
    localparam ST_PUSH = 6'b000010;
    localparam ST_MASK = 6'b000100;
    localparam ST_VEC = 6'b001000;
    localparam ST_PULL = 6'b010000;
    localparam ST_RESET = 6'b100000;

    wire ext_sync;
    cfis_sync u_sync (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_async(~i_ext_irq_n),
        .o_sync(ext_sync)
    );

    reg [4:0] flags_reg;
    reg [5:0] state_reg;
    reg [15:0] pc_reg;
    reg [5:0] sp_reg;
    reg [7:0] acc_reg;
    reg [7:0] idx_reg;
    reg [7:0] operand_reg;
    reg [3:0] op_reg;
    reg [3:0] enable_reg;
    reg [2:0] step_reg;
    reg [15:0] vec_reg;
    reg insn_busy_reg;
    reg swi_req_reg;
    reg rti_req_reg;
    reg [7:0] result_reg;
    reg [31:0] stack_mem_pull;
    reg [7:0] stack_mem [0:63];

    // Bus address phase capture
    reg wr_pend_reg;
    reg [11:0] addr_reg;
    wire take = i_hsel && i_hready && i_htrans[1];

    wire [7:0] alu_res;
    wire [4:0] alu_flags;
    cfis_alu_flags u_alu (
        .i_op(op_reg),
        .i_a(acc_reg),
        .i_b(operand_reg),
        .i_flags(flags_reg),
        .o_result(alu_res),
        .o_flags(alu_flags)
    );

    // Pending requests gated by local enables
    wire [3:0] pend;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pend
            wire req_in;
            if (g == 0) begin : g_e
                assign req_in = ext_sync;
            end else if (g == 1) begin : g_s
                assign req_in = i_ser_req;
            end else if (g == 2) begin : g_t
                assign req_in = i_tmr_req;
            end else begin : g_m
                assign req_in = i_mft_req;
            end
            assign pend[g] = req_in & enable_reg[g];
        end
    endgenerate
    wire hw_take = (|pend) && !flags_reg[`CFIS_BIT_I];

    // Highest vector location wins
    reg [15:0] hw_vec;
    always @* begin
        if (pend[0]) begin
            hw_vec = `CFIS_VEC_EXT;
        end else if (pend[1]) begin
            hw_vec = `CFIS_VEC_SER;
        end else if (pend[2]) begin
            hw_vec = `CFIS_VEC_TMR;
        end else begin
            hw_vec = `CFIS_VEC_MFT;
        end
    end

    reg [7:0] push_byte;
    always @* begin
        case (step_reg)
            3'd0: push_byte = pc_reg[7:0];
            3'd1: push_byte = pc_reg[15:8];
            3'd2: push_byte = idx_reg;
            3'd3: push_byte = acc_reg;
            default: push_byte = {`CFIS_FLAGS_UPPER, flags_reg};
        endcase
    end

    wire [4:0] flags_rd = flags_reg;
    wire [5:0] sp_up = sp_reg + 6'd1;

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_reg <= ST_RESET;
            flags_reg <= `CFIS_FLAGS_RESET;
            pc_reg <= 16'h0000;
            sp_reg <= `CFIS_SP_RESET;
            acc_reg <= 8'h00;
            idx_reg <= 8'h00;
            operand_reg <= 8'h00;
            op_reg <= `CFIS_OP_LOAD;
            enable_reg <= `CFIS_ENABLE_RESET;
            step_reg <= 3'd0;
            vec_reg <= `CFIS_VEC_RESET;
            insn_busy_reg <= 1'b0;
            swi_req_reg <= 1'b0;
            rti_req_reg <= 1'b0;
            result_reg <= 8'h00;
            wr_pend_reg <= 1'b0;
            addr_reg <= 12'h000;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            o_stack_addr <= 16'h0000;
            o_stack_data <= 8'h00;
            o_stack_we <= 1'b0;
            o_vector_addr <= 16'h0000;
            o_vector_fetch <= 1'b0;
            stack_mem_pull <= 32'h0000_0000;
        end else begin
            o_stack_we <= 1'b0;
            o_vector_fetch <= 1'b0;
            o_hresp <= 1'b0;
            wr_pend_reg <= take && i_hwrite;
            if (take) begin
                addr_reg <= i_haddr[11:0];
            end
            case (state_reg)
                ST_RESET: begin
                    o_vector_addr <= `CFIS_VEC_RESET;
                    o_vector_fetch <= 1'b1;
                    pc_reg <= `CFIS_VEC_RESET;
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (insn_busy_reg) begin
                        // Instruction executes; interrupts wait for it
                        acc_reg <= alu_res;
                        result_reg <= alu_res;
                        flags_reg <= alu_flags;
                        insn_busy_reg <= 1'b0;
                        pc_reg <= pc_reg + 16'h0001;
                    end else if (rti_req_reg) begin
                        rti_req_reg <= 1'b0;
                        step_reg <= 3'd0;
                        state_reg <= ST_PULL;
                    end else if (hw_take) begin
                        step_reg <= 3'd0;
                        vec_reg <= 16'h0000;
                        state_reg <= ST_PUSH;
                    end else if (swi_req_reg) begin
                        swi_req_reg <= 1'b0;
                        step_reg <= 3'd0;
                        vec_reg <= `CFIS_VEC_SWI;
                        state_reg <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    o_stack_addr <= {`CFIS_STACK_BASE, sp_reg};
                    o_stack_data <= push_byte;
                    o_stack_we <= 1'b1;
                    stack_mem[sp_reg] <= push_byte;
                    sp_reg <= sp_reg - 6'd1;
                    step_reg <= step_reg + 3'd1;
                    if (step_reg == 3'd4) begin
                        state_reg <= ST_MASK;
                    end
                end
                ST_MASK: begin
                    flags_reg[`CFIS_BIT_I] <= 1'b1;
                    state_reg <= ST_VEC;
                end
                ST_VEC: begin
                    if (vec_reg == 16'h0000 && hw_vec != 16'h0000) begin
                        o_vector_addr <= hw_vec;
                        pc_reg <= hw_vec;
                    end else begin
                        o_vector_addr <= vec_reg;
                        pc_reg <= vec_reg;
                    end
                    o_vector_fetch <= 1'b1;
                    state_reg <= ST_RUN;
                end
                ST_PULL: begin
                    o_stack_addr <= {`CFIS_STACK_BASE, sp_up};
                    sp_reg <= sp_up;
                    step_reg <= step_reg + 3'd1;
                    stack_mem_pull <= {stack_mem_pull[23:0], stack_mem[sp_up]};
                    if (step_reg == 3'd4) begin
                        // Reverse order: flags, acc, index, pc high, pc low
                        flags_reg <= stack_mem_pull[28:24];
                        acc_reg <= stack_mem_pull[23:16];
                        idx_reg <= stack_mem_pull[15:8];
                        pc_reg <= {stack_mem_pull[7:0], stack_mem[sp_up]};
                        state_reg <= ST_RUN;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
            if (wr_pend_reg) begin
                case (addr_reg)
                    `CFIS_OFF_ALU: begin
                        if (state_reg == ST_RUN && !insn_busy_reg) begin
                            op_reg <= i_hwdata[3:0];
                            insn_busy_reg <= 1'b1;
                        end
                    end
                    `CFIS_OFF_CTRL: begin
                        if (i_hwdata[0]) begin
                            swi_req_reg <= 1'b1;
                        end
                        if (i_hwdata[1]) begin
                            rti_req_reg <= 1'b1;
                        end
                    end
                    `CFIS_OFF_ENABLE: enable_reg <= i_hwdata[3:0];
                    `CFIS_OFF_AX: begin
                        if (state_reg == ST_RUN && !insn_busy_reg) begin
                            acc_reg <= i_hwdata[7:0];
                            idx_reg <= i_hwdata[15:8];
                            operand_reg <= i_hwdata[23:16];
                        end
                    end
                    default: op_reg <= op_reg;
                endcase
            end
            // Read data loaded in the address phase so it stands in the data phase
            if (take && !i_hwrite) begin
                case (i_haddr[11:0])
                    `CFIS_OFF_FLAGS: o_hrdata <= {24'h00_0000, `CFIS_FLAGS_UPPER, flags_rd};
                    `CFIS_OFF_STATUS: o_hrdata <= {20'h0_0000, pend, 2'b00, state_reg};
                    `CFIS_OFF_ENABLE: o_hrdata <= {28'h000_0000, enable_reg};
                    `CFIS_OFF_PC: o_hrdata <= {16'h0000, pc_reg};
                    `CFIS_OFF_SP: o_hrdata <= {26'h000_0000, sp_reg};
                    `CFIS_OFF_AX: o_hrdata <= {8'h00, operand_reg, idx_reg, acc_reg};
                    `CFIS_OFF_RES: o_hrdata <= {24'h00_0000, result_reg};
                    default: o_hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ==== include/cfis_defines.vh ====
// Constants for the flag and interrupt sequencer
`ifndef CFIS_DEFINES_VH
`define CFIS_DEFINES_VH
// Register byte addresses on the bus
`define CFIS_OFF_FLAGS 12'h000
`define CFIS_OFF_CTRL 12'h004
`define CFIS_OFF_STATUS 12'h008
`define CFIS_OFF_ENABLE 12'h00C
`define CFIS_OFF_PC 12'h010
`define CFIS_OFF_SP 12'h014
`define CFIS_OFF_AX 12'h018
`define CFIS_OFF_ALU 12'h01C
`define CFIS_OFF_RES 12'h020
// Flag bit positions
`define CFIS_BIT_C 0
`define CFIS_BIT_Z 1
`define CFIS_BIT_N 2
`define CFIS_BIT_I 3
`define CFIS_BIT_H 4
`define CFIS_FLAGS_UPPER 3'b111
// Reset values
`define CFIS_FLAGS_RESET 5'h08
`define CFIS_SP_RESET 6'h3F
`define CFIS_ENABLE_RESET 4'h1
// Vector addresses
`define CFIS_VEC_RESET 16'h1FFE
`define CFIS_VEC_SWI 16'h1FFC
`define CFIS_VEC_EXT 16'h1FFA
`define CFIS_VEC_SER 16'h1FF8
`define CFIS_VEC_TMR 16'h1FF6
`define CFIS_VEC_MFT 16'h1FF4
`define CFIS_STACK_BASE 10'b0000_0000_11
`define CFIS_INT_BYTES 5
// Operation codes written to the ALU register
`define CFIS_OP_ADD 4'h0
`define CFIS_OP_ADC 4'h1
`define CFIS_OP_SUB 4'h2
`define CFIS_OP_AND 4'h3
`define CFIS_OP_LOAD 4'h4
`define CFIS_OP_INC 4'h5
`define CFIS_OP_DEC 4'h6
`define CFIS_OP_LSL 4'h7
`define CFIS_OP_LSR 4'h8
`define CFIS_OP_BTB 4'h9
`define CFIS_OP_CLI 4'hA
`define CFIS_OP_WAIT 4'hB
`define CFIS_OP_SEI 4'hC
`endif

// ==== verilog/cfis_sync.v ====
// Two-flop synchroniser for the external request pin
`timescale 1ns/1ps
module cfis_sync (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_async,
    output reg o_sync
);
    reg meta_reg;
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            meta_reg <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule

// ==== verilog/cfis_alu_flags.v ====
// Flag computation for one arithmetic or logic operation
`timescale 1ns/1ps
`include "cfis_defines.vh"
module cfis_alu_flags (
    input wire [3:0] i_op,
    input wire [7:0] i_a,
    input wire [7:0] i_b,
    input wire [4:0] i_flags,
    output reg [7:0] o_result,
    output reg [4:0] o_flags
);
    reg [8:0] sum;
    reg [4:0] low;
    reg cin;
    always @* begin
        sum = 9'h000;
        low = 5'h00;
        cin = (i_op == `CFIS_OP_ADC) ? i_flags[`CFIS_BIT_C] : 1'b0;
        o_flags = i_flags;
        o_result = i_a;
        case (i_op)
            `CFIS_OP_ADD, `CFIS_OP_ADC: begin
                sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
                low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
                o_result = sum[7:0];
                o_flags[`CFIS_BIT_H] = low[4];
                o_flags[`CFIS_BIT_C] = sum[8];
            end
            `CFIS_OP_SUB: begin
                sum = {1'b0, i_a} - {1'b0, i_b};
                o_result = sum[7:0];
                o_flags[`CFIS_BIT_C] = sum[8];
            end
            `CFIS_OP_AND: o_result = i_a & i_b;
            `CFIS_OP_LOAD: o_result = i_b;
            `CFIS_OP_INC: o_result = i_a + 8'h01;
            `CFIS_OP_DEC: o_result = i_a - 8'h01;
            `CFIS_OP_LSL: begin
                o_result = {i_a[6:0], 1'b0};
                o_flags[`CFIS_BIT_C] = i_a[7];
            end
            `CFIS_OP_LSR: begin
                o_result = {1'b0, i_a[7:1]};
                o_flags[`CFIS_BIT_C] = i_a[0];
            end
            `CFIS_OP_BTB: begin
                o_result = i_a;
                o_flags[`CFIS_BIT_C] = i_a[i_b[2:0]];
            end
            default: o_result = i_a;
        endcase
        if (i_op <= `CFIS_OP_LSR) begin
            o_flags[`CFIS_BIT_N] = o_result[7];
            o_flags[`CFIS_BIT_Z] = (o_result == 8'h00);
        end
        if (i_op == `CFIS_OP_BTB) begin
            o_flags[`CFIS_BIT_N] = i_flags[`CFIS_BIT_N];
            o_flags[`CFIS_BIT_Z] = i_flags[`CFIS_BIT_Z];
        end
        if (i_op == `CFIS_OP_CLI || i_op == `CFIS_OP_WAIT) begin
            o_flags[`CFIS_BIT_I] = 1'b0;
        end
        if (i_op == `CFIS_OP_SEI) begin
            o_flags[`CFIS_BIT_I] = 1'b1;
        end
    end
endmodule

// ==== dv/cfis_checker.sv ====
// Assertion checker for stacking and vectoring outputs
`timescale 1ns/1ps
module cfis_checker (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_ext_irq_n,
    input wire [15:0] o_stack_addr,
    input wire [7:0] o_stack_data,
    input wire o_stack_we,
    input wire [15:0] o_vector_addr,
    input wire o_vector_fetch
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    sequence push_five_s;
        o_stack_we [*5];
    endsequence
    sequence mask_then_fetch_s;
        !o_stack_we ##[1:2] o_vector_fetch;
    endsequence
    reset_vector_a: assert property ($rose(i_reset_n) |->
        ##[0:2] (o_vector_fetch && o_vector_addr == 16'h1FFE)) else $error("no reset vector");
    entry_order_a: assert property ($rose(o_stack_we) |->
        push_five_s ##1 mask_then_fetch_s) else $error("bad entry sequence");
    stack_window_a: assert property (o_stack_we |->
        o_stack_addr[15:6] == 10'b0000_0000_11) else $error("stack address out of page");
    stack_descend_a: assert property (o_stack_we && $past(o_stack_we) |->
        ((o_stack_addr + 16'h0001) & 16'h003F) == ($past(o_stack_addr) & 16'h003F))
        else $error("stack not descending");
    flags_upper_a: assert property ($fell(o_stack_we) |->
        ($past(o_stack_data) & 8'hE0) == 8'hE0) else $error("stacked flags upper bits");
    vector_table_a: assert property (o_vector_fetch |-> o_vector_addr >= 16'h1FF4 &&
        o_vector_addr <= 16'h1FFE && !o_vector_addr[0]) else $error("vector outside table");
    fetch_after_push_a: assert property (o_vector_fetch && o_vector_addr != 16'h1FFE |->
        $past(o_stack_we, 2) && !$past(o_stack_we)) else $error("fetch not after stacking");
    ext_synced_a: assert property (o_vector_fetch && o_vector_addr == 16'h1FFA |->
        $past(i_ext_irq_n, 3) == 1'b0) else $error("pin taken too early");
endmodule
bind cfis_top cfis_checker u_cfis_checker (.i_mclk, .i_reset_n, .i_ext_irq_n, .o_stack_addr,
    .o_stack_data, .o_stack_we, .o_vector_addr, .o_vector_fetch);

// ==== dv/cfis_irq_model.sv ====
// Request sources that hold a level until their vector is fetched
`timescale 1ns/1ps
module cfis_irq_model (
    input wire i_mclk,
    input wire i_reset_n,
    input wire [3:0] i_raise,
    input wire [15:0] i_vector_addr,
    input wire i_vector_fetch,
    output wire o_ext_irq_n,
    output wire o_ser_req,
    output wire o_tmr_req,
    output wire o_mft_req
);
    logic [3:0] req_reg;
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            req_reg <= 4'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (i_raise[k]) begin
                    req_reg[k] <= 1'b1;
                end else if (i_vector_fetch && i_vector_addr == 16'h1FFA - 16'(2 * k)) begin
                    req_reg[k] <= 1'b0;
                end
            end
        end
    end
    assign o_ext_irq_n = ~req_reg[0];
    assign o_ser_req = req_reg[1];
    assign o_tmr_req = req_reg[2];
    assign o_mft_req = req_reg[3];
endmodule

// ==== dv/cfis_tb_top.sv ====
// Testbench for the flag and interrupt sequencer
`timescale 1ns/1ps
`include "cfis_defines.vh"
module cfis_tb_top;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:0] raise = 4'h0;
    wire [31:0] hrdata;
    wire [15:0] saddr;
    wire [15:0] vaddr;
    wire [7:0] sdata;
    wire hready, hresp, ext_n, ser, tmr, mft, vfetch, swe;
    integer err_count = 0;
    integer checks = 0;
    integer pushes = 0;
    integer p;
    logic [7:0] last_push;
    logic [15:0] vq[$];
    logic [31:0] r;
    always #12.5 i_mclk = ~i_mclk;
    cfis_top u_cfis_top (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ext_irq_n(ext_n),
        .i_ser_req(ser), .i_tmr_req(tmr), .i_mft_req(mft), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_stack_addr(saddr), .o_stack_data(sdata), .o_stack_we(swe),
        .o_vector_addr(vaddr), .o_vector_fetch(vfetch));
    cfis_irq_model u_cfis_irq_model (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_raise(raise),
        .i_vector_addr(vaddr), .i_vector_fetch(vfetch), .o_ext_irq_n(ext_n),
        .o_ser_req(ser), .o_tmr_req(tmr), .o_mft_req(mft));
    always @(posedge i_mclk) begin
        if (i_reset_n && vfetch === 1'b1) vq.push_back(vaddr);
        if (swe === 1'b1) begin
            pushes <= pushes + 1;
            last_push <= sdata;
        end
    end
    task conclude;
        if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task timed_out;
        $display("wrong value at %0t: wait ran out", $time);
        err_count++;
        conclude();
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks++;
        if ((got & m) !== (exp & m)) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask
    task wait_ready;
        integer n;
        n = 0;
        @(posedge i_mclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) timed_out();
            @(posedge i_mclk);
        end
    endtask
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        r = hrdata;
    endtask
    task alu(input logic [3:0] op, input logic [7:0] acc, input logic [7:0] opd);
        bus(1'b1, `CFIS_OFF_AX, {8'h00, opd, 8'h00, acc});
        @(posedge i_mclk);
        bus(1'b1, `CFIS_OFF_ALU, {28'h000_0000, op});
        repeat (2) @(posedge i_mclk);
    endtask
    task alu_chk(input logic [3:0] op, input logic [7:0] acc, opd, res, flg, msk);
        alu(op, acc, opd);
        if (op != 4'h9) begin
            bus(1'b0, `CFIS_OFF_RES, 32'h0000_0000);
            chk(r, {24'h00_0000, res}, 32'h0000_00FF);
        end
        bus(1'b0, `CFIS_OFF_FLAGS, 32'h0000_0000);
        chk(r, {24'h00_0000, flg}, {24'h00_0000, msk});
    endtask
    task expect_vec(input logic [15:0] exp);
        integer n;
        n = 0;
        while (vq.size() == 0) begin
            n++;
            if (n > 200) timed_out();
            @(posedge i_mclk);
            #1;
        end
        chk({16'h0000, vq.pop_front()}, {16'h0000, exp}, 32'h0000_FFFF);
        repeat (3) @(posedge i_mclk);
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(1'b0, a, 32'h0000_0000);
        chk(r, exp, m);
    endtask
    task return_from_interrupt;
        bus(1'b1, `CFIS_OFF_CTRL, 32'h0000_0002);
        repeat (10) @(posedge i_mclk);
    endtask
    task pulse_raise(input logic [3:0] v);
        raise <= v;
        @(posedge i_mclk);
        raise <= 4'h0;
        repeat (20) @(posedge i_mclk);
    endtask
    initial begin
        repeat (20) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        expect_vec(16'h1FFE);
        rd_chk(`CFIS_OFF_FLAGS, 32'h0000_00E8, 32'h0000_00E8);
        rd_chk(`CFIS_OFF_SP, 32'h0000_003F, 32'h0000_003F);
        rd_chk(`CFIS_OFF_ENABLE, 32'h0000_0001, 32'h0000_000F);
        chk({31'h0000_0000, hresp}, 32'h0000_0000, 32'h0000_0001);
        alu_chk(4'h0, 8'h0F, 8'h01, 8'h10, 8'h10, 8'h17);
        alu_chk(4'h0, 8'h80, 8'h80, 8'h00, 8'h03, 8'h17);
        alu_chk(4'h5, 8'hFF, 8'h00, 8'h00, 8'h03, 8'h07);
        alu_chk(4'h6, 8'h00, 8'h00, 8'hFF, 8'h05, 8'h07);
        alu_chk(4'h1, 8'h0E, 8'h01, 8'h10, 8'h10, 8'h17);
        alu_chk(4'h2, 8'h00, 8'h01, 8'hFF, 8'h05, 8'h07);
        alu_chk(4'h4, 8'h00, 8'h00, 8'h00, 8'h02, 8'h06);
        alu_chk(4'h7, 8'h81, 8'h00, 8'h02, 8'h01, 8'h07);
        alu_chk(4'h8, 8'h01, 8'h00, 8'h00, 8'h03, 8'h07);
        alu_chk(4'h3, 8'hF0, 8'h8F, 8'h80, 8'h04, 8'h06);
        alu_chk(4'h9, 8'h08, 8'h03, 8'h00, 8'h01, 8'h01);
        bus(1'b1, `CFIS_OFF_ENABLE, 32'h0000_000F);
        pulse_raise(4'b1100);
        chk(32'(vq.size()), 32'h0000_0000, 32'hFFFF_FFFF);
        rd_chk(`CFIS_OFF_STATUS, 32'h0000_0C00, 32'h0000_0F00);
        p = pushes;
        alu(4'hA, 8'h00, 8'h00);
        expect_vec(16'h1FF6);
        chk(32'(pushes - p), 32'h0000_0005, 32'hFFFF_FFFF);
        chk({24'h00_0000, last_push}, 32'h0000_00E0, 32'h0000_00E8);
        rd_chk(`CFIS_OFF_FLAGS, 32'h0000_0008, 32'h0000_0008);
        rd_chk(`CFIS_OFF_SP, 32'h0000_003A, 32'h0000_003F);
        return_from_interrupt();
        expect_vec(16'h1FF4);
        return_from_interrupt();
        rd_chk(`CFIS_OFF_FLAGS, 32'h0000_0000, 32'h0000_0008);
        rd_chk(`CFIS_OFF_SP, 32'h0000_003F, 32'h0000_003F);
        bus(1'b1, `CFIS_OFF_ENABLE, 32'h0000_000B);
        pulse_raise(4'b0100);
        chk(32'(vq.size()), 32'h0000_0000, 32'hFFFF_FFFF);
        pulse_raise(4'b0011);
        expect_vec(16'h1FFA);
        return_from_interrupt();
        expect_vec(16'h1FF8);
        return_from_interrupt();
        alu(4'hC, 8'h00, 8'h00);
        bus(1'b1, `CFIS_OFF_CTRL, 32'h0000_0001);
        expect_vec(16'h1FFC);
        return_from_interrupt();
        rd_chk(`CFIS_OFF_FLAGS, 32'h0000_0008, 32'h0000_0008);
        raise <= 4'h1;
        @(posedge i_mclk);
        raise <= 4'h0;
        rd_chk(`CFIS_OFF_STATUS, 32'h0000_0000, 32'h0000_0100);
        rd_chk(`CFIS_OFF_STATUS, 32'h0000_0100, 32'h0000_0100);
        alu(4'hB, 8'h00, 8'h00);
        rd_chk(`CFIS_OFF_FLAGS, 32'h0000_0000, 32'h0000_0008);
        expect_vec(16'h1FFA);
        bus(1'b1, `CFIS_OFF_CTRL, 32'h0000_0002);
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        expect_vec(16'h1FFE);
        rd_chk(`CFIS_OFF_FLAGS, 32'h0000_0008, 32'h0000_0008);
        rd_chk(`CFIS_OFF_SP, 32'h0000_003F, 32'h0000_003F);
        conclude();
    end
endmodule
